/* eptmr_top.sv */
// eight bit period timer with prescaler, postscaler and apb registers
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "eptmr_regs.svh"
module eptmr_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        sleepMode,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             pwmTimeBase,
    output logic             shiftClock,
    output logic             irq
);
    logic [7:0] control_r;
    logic [7:0] timerCount_r;
    logic [7:0] periodValue_r;
    logic       matchIrqFlag_r;
    logic       matchIrqEnable_r;
    logic       shiftSel_r;
    logic [1:0] instrDiv_r;
    logic [5:0] preCount_r;
    logic       sleepMeta_r;
    logic       sleepSync_r;
    logic       pwmTimeBase_r;
    logic       shiftClock_r;

    logic       wrAcc;
    logic       rdAcc;
    logic       addrOk;
    logic       wrControl;
    logic       wrCount;
    logic       clearScalers;
    logic       instrTick;
    logic       timerTick;
    logic       matchNow;
    logic       matchPulse;
    logic       postEvent;
    logic [5:0] preTop;
    logic       timerOn;
    logic       running;
    eptmr_pkg::eptmr_prescale_type prescaleSelect;
    logic [3:0] postscaleSelect;

    // apb: zero wait states, unmapped addresses answer with an error
    assign pready = 1'b1;
    assign addrOk = (paddr == `EPTMR_OFF_CONTROL) || (paddr == `EPTMR_OFF_COUNT)
                 || (paddr == `EPTMR_OFF_PERIOD) || (paddr == `EPTMR_OFF_IRQ_FLAG)
                 || (paddr == `EPTMR_OFF_IRQ_EN) || (paddr == `EPTMR_OFF_SHIFT_SEL);
    assign pslverr = psel && penable && !addrOk;
    assign wrAcc = psel && penable && pwrite && addrOk && pstrb[0];
    assign rdAcc = psel && penable && !pwrite && addrOk;
    assign wrControl = wrAcc && (paddr == `EPTMR_OFF_CONTROL);
    assign wrCount = wrAcc && (paddr == `EPTMR_OFF_COUNT);
    assign clearScalers = wrControl || wrCount;

    // sleep comes from another power domain, so it is synchronised first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleepMeta_r <= 1'b0;
            sleepSync_r <= 1'b0;
        end else if (ce) begin
            sleepMeta_r <= sleepMode;
            sleepSync_r <= sleepMeta_r;
        end
    end

    // field decode of the control register
    assign prescaleSelect = eptmr_pkg::eptmr_prescale_type'(control_r[`EPTMR_CKPS_LSB +: 2]);
    assign postscaleSelect = control_r[`EPTMR_OUTPS_LSB +: 4];
    assign timerOn = control_r[`EPTMR_ON_BIT];
    assign running = timerOn && !sleepSync_r;

    // instruction clock: one tick every fourth system clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instrDiv_r <= 2'h0;
        end else if (ce) begin
            instrDiv_r <= instrDiv_r + 2'h1;
        end
    end
    assign instrTick = (instrDiv_r == `EPTMR_INSTR_DIV);

    // prescale terminal value per selection
    always_comb begin
        case (prescaleSelect)
            eptmr_pkg::EPTMR_PRE_1:  preTop = 6'h00;
            eptmr_pkg::EPTMR_PRE_4:  preTop = 6'h03;
            eptmr_pkg::EPTMR_PRE_16: preTop = 6'h0f;
            eptmr_pkg::EPTMR_PRE_64: preTop = 6'h3f;
            default:                 preTop = 6'h00;
        endcase
    end
    assign timerTick = running && instrTick && (preCount_r >= preTop);

    // prescaler counter; held while off or asleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preCount_r <= 6'h00;
        end else if (ce) begin
            if (clearScalers) begin
                preCount_r <= 6'h00;
            end else if (running && instrTick) begin
                preCount_r <= timerTick ? 6'h00 : preCount_r + 6'h01;
            end
        end
    end

    // compare is evaluated on the tick so the match is one clock wide
    assign matchNow = (timerCount_r == periodValue_r);
    assign matchPulse = timerTick && matchNow && !clearScalers;

    // count register; a control write does not touch it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timerCount_r <= `EPTMR_COUNT_RST;
        end else if (ce) begin
            if (wrCount) begin
                timerCount_r <= pwdata[7:0];
            end else if (timerTick && !wrControl) begin
                // equality returns to zero, giving period value plus one ticks
                timerCount_r <= matchNow ? 8'h00 : timerCount_r + 8'h01;
            end
        end
    end

    // period and control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periodValue_r <= `EPTMR_PERIOD_RST;
            control_r <= `EPTMR_CONTROL_RST;
        end else if (ce) begin
            if (wrAcc && (paddr == `EPTMR_OFF_PERIOD)) begin
                periodValue_r <= pwdata[7:0];
            end
            if (wrControl) begin
                control_r <= pwdata[7:0] & `EPTMR_CONTROL_MASK;
            end
        end
    end

    eptmr_postscaler u_post (
        .clk             (clk),
        .rst_n           (rst_n),
        .ce              (ce),
        .clear           (clearScalers),
        .matchPulse      (matchPulse),
        .postscaleSelect (postscaleSelect),
        .eventPulse      (postEvent)
    );

    // sticky flag: a new event wins over a write-one-to-clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            matchIrqFlag_r <= 1'b0;
        end else if (ce) begin
            if (postEvent) begin
                matchIrqFlag_r <= 1'b1;
            end else if (wrAcc && (paddr == `EPTMR_OFF_IRQ_FLAG) && pwdata[0]) begin
                matchIrqFlag_r <= 1'b0;
            end
        end
    end

    // enable and shift clock select bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            matchIrqEnable_r <= 1'b0;
            shiftSel_r <= 1'b0;
        end else if (ce) begin
            if (wrAcc && (paddr == `EPTMR_OFF_IRQ_EN)) begin
                matchIrqEnable_r <= pwdata[0];
            end
            if (wrAcc && (paddr == `EPTMR_OFF_SHIFT_SEL)) begin
                shiftSel_r <= pwdata[0];
            end
        end
    end
    assign irq = matchIrqFlag_r && matchIrqEnable_r;

    // registered match outputs for the pwm units and serial port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwmTimeBase_r <= 1'b0;
            shiftClock_r <= 1'b0;
        end else if (ce) begin
            pwmTimeBase_r <= matchPulse;
            shiftClock_r <= matchPulse && shiftSel_r;
        end
    end
    assign pwmTimeBase = pwmTimeBase_r;
    assign shiftClock = shiftClock_r;

    // read data is registered during the setup phase for a clean access phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `EPTMR_OFF_CONTROL:   prdata <= {24'h000000, control_r};
                    `EPTMR_OFF_COUNT:     prdata <= {24'h000000, timerCount_r};
                    `EPTMR_OFF_PERIOD:    prdata <= {24'h000000, periodValue_r};
                    `EPTMR_OFF_IRQ_FLAG:  prdata <= {31'h00000000, matchIrqFlag_r};
                    `EPTMR_OFF_IRQ_EN:    prdata <= {31'h00000000, matchIrqEnable_r};
                    `EPTMR_OFF_SHIFT_SEL: prdata <= {31'h00000000, shiftSel_r};
                    default:              prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

/* eptmr_regs.svh */
// register offsets, field positions, reset values and timing counts of the period timer
// Notes on behaviour
// - timer ticks from system clock divided by four, then the prescaler
// - control bits 1-0 select prescale 1, 4, 16 or 64
// - count is compared with period each timer tick; equality gives match
// - after a match the count returns to zero on the next tick
// - control bits 6-3 divide matches by field value plus one
// - completing the postscale count sets the sticky match interrupt flag
// - match interrupt reaches the interrupt output only while its enable is set
// - count and period read/write; reset gives count 00 and period ff
// - prescaler and postscaler clear on count write, control write, any reset
// - control register writes leave the count unchanged
// - control bit 2 turns timer on; bit 7 reads zero
// - unscaled match pulse goes out as the pwm time base
// - match pulse selectable as serial port shift clock
// - during sleep only the divide-by-four counter runs; count and period hold
// - counter period is period value plus one timer ticks
`ifndef EPTMR_REGS_SVH
`define EPTMR_REGS_SVH

`define EPTMR_OFF_CONTROL   12'h000
`define EPTMR_OFF_COUNT     12'h004
`define EPTMR_OFF_PERIOD    12'h008
`define EPTMR_OFF_IRQ_FLAG  12'h00c
`define EPTMR_OFF_IRQ_EN    12'h010
`define EPTMR_OFF_SHIFT_SEL 12'h014

`define EPTMR_CKPS_LSB      0
`define EPTMR_ON_BIT        2
`define EPTMR_OUTPS_LSB     3
`define EPTMR_CONTROL_MASK  8'h7f
`define EPTMR_CONTROL_RST   8'h00
`define EPTMR_COUNT_RST     8'h00
`define EPTMR_PERIOD_RST    8'hff

`define EPTMR_INSTR_DIV     2'h3
`endif

/* eptmr_pkg.sv */
// types shared by the period timer files
package eptmr_pkg;
    typedef enum logic [1:0] {
        EPTMR_PRE_1,
        EPTMR_PRE_4,
        EPTMR_PRE_16,
        EPTMR_PRE_64
    } eptmr_prescale_type;
endpackage

/* eptmr_postscaler.sv */
// postscaler counting match pulses into interrupt events
`timescale 1ns/100ps
module eptmr_postscaler (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       clear,
    input  wire logic       matchPulse,
    input  wire logic [3:0] postscaleSelect,
    output logic            eventPulse
);
    logic [3:0] postCount_r;

    // event fires on the last match of the chosen group
    assign eventPulse = matchPulse && (postCount_r == postscaleSelect);

    // count restarts on clear so the first group is always full length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            postCount_r <= 4'h0;
        end else if (ce) begin
            if (clear) begin
                postCount_r <= 4'h0;
            end else if (eventPulse) begin
                postCount_r <= 4'h0;
            end else if (matchPulse) begin
                postCount_r <= postCount_r + 4'h1;
            end
        end
    end
endmodule

/* eptmr_monitor.sv */
// concurrent checks on the period timer ports
`timescale 1ns/100ps
`include "eptmr_regs.svh"
module eptmr_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        sleepMode,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        pwmTimeBase,
    input wire logic        shiftClock,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // access phase decode; only six words answer
    wire acc = psel && penable;
    wire rdAcc = acc && !pwrite;
    wire mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};
    sequence s_pulse; pwmTimeBase; endsequence
    sequence s_quiet; !pwmTimeBase [*3]; endsequence
    property p_gap; s_pulse |=> s_quiet; endproperty
    property p_sleep; sleepMode [*6] |-> !pwmTimeBase; endproperty
    property p_shift; shiftClock |-> pwmTimeBase; endproperty
    property p_err; pslverr |-> acc && !mapped; endproperty
    property p_unmap; acc && !mapped |-> pslverr; endproperty
    property p_bit7; rdAcc && paddr == `EPTMR_OFF_CONTROL |-> prdata[31:7] == 25'h0; endproperty
    property p_upper; rdAcc |-> prdata[31:8] == 24'h0; endproperty
    property p_mask;
        acc && pwrite && paddr == `EPTMR_OFF_IRQ_EN && pstrb[0] && !pwdata[0] |=> !irq;
    endproperty
    a_gap: assert property (p_gap) else $error("match pulses under four clocks apart");
    a_sleep: assert property (p_sleep) else $error("match pulse during sleep");
    a_shift: assert property (p_shift) else $error("shift clock without match");
    a_err: assert property (p_err) else $error("error on a mapped word");
    a_unmap: assert property (p_unmap) else $error("no error on unmapped word");
    a_bit7: assert property (p_bit7) else $error("control bit 7 reads one");
    a_upper: assert property (p_upper) else $error("upper read bits set");
    a_mask: assert property (p_mask) else $error("irq high while disabled");
endmodule
bind eptmr_top eptmr_monitor mon (.clk(clk), .rst_n(rst_n), .sleepMode(sleepMode),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .pwmTimeBase(pwmTimeBase),
    .shiftClock(shiftClock), .irq(irq));

/* eptmr_partner.sv */
// far side model: pwm unit and serial port counting timer pulses
`timescale 1ns/100ps
module eptmr_partner (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pwmTimeBase,
    input  wire logic shiftClock,
    output int        pwmCount,
    output int        shiftCount
);
    // pulses last one clock, so a level sample counts each once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwmCount <= 0;
            shiftCount <= 0;
        end else begin
            pwmCount <= pwmCount + int'(pwmTimeBase);
            shiftCount <= shiftCount + int'(shiftClock);
        end
    end
endmodule

/* test_eight_bit_period_timer.sv */
// self-checking bench for the period timer
`timescale 1ns/100ps
`include "eptmr_regs.svh"
module test_eight_bit_period_timer;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sleepMode = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, pwmTimeBase, shiftClock, irq;
    int          failCount = 0, comparisons = 0, pwmCount, shiftCount, t, n, p, q;
    int          mdl [int];
    always #25 clk = ~clk;
    eptmr_top DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .sleepMode(sleepMode), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwmTimeBase(pwmTimeBase),
        .shiftClock(shiftClock), .irq(irq));
    eptmr_partner far (.clk(clk), .rst_n(rst_n), .pwmTimeBase(pwmTimeBase),
        .shiftClock(shiftClock), .pwmCount(pwmCount), .shiftCount(shiftCount));
    task endOfTest;
        if (failCount == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer; request held until pready is seen
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // write and keep the model in step; flag is write-one-clear so not modelled
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
        if (a == `EPTMR_OFF_CONTROL) mdl[a] = d & 32'h7f;
        else if (a != `EPTMR_OFF_IRQ_FLAG) mdl[a] = d & (a < 12'h00c ? 32'hff : 32'h1);
    endtask
    task rdchk(input logic [11:0] a);
        apb(a, 1'b0, 32'h0);
        chk($sformatf("reg %h", a), rd, mdl.exists(a) ? mdl[a] : 0);
    endtask
    task waitp(output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (pwmTimeBase !== 1'b1 && c < 20000);
    endtask
    initial begin
        q = $urandom(96);
        mdl[`EPTMR_OFF_CONTROL] = `EPTMR_CONTROL_RST;
        mdl[`EPTMR_OFF_COUNT] = `EPTMR_COUNT_RST;
        mdl[`EPTMR_OFF_PERIOD] = `EPTMR_PERIOD_RST;
        mdl[`EPTMR_OFF_IRQ_FLAG] = 0;
        mdl[`EPTMR_OFF_IRQ_EN] = 0;
        mdl[`EPTMR_OFF_SHIFT_SEL] = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, an unmapped word, bit 7 held at zero
        foreach (mdl[a]) rdchk(a);
        rdchk(12'h018);
        wr(`EPTMR_OFF_CONTROL, 32'hff);
        rdchk(`EPTMR_OFF_CONTROL);
        wr(`EPTMR_OFF_CONTROL, 32'h0);
        // pulse spacing for every prescale code
        for (int c = 0; c < 4; c++) begin
            p = $urandom_range(6, 0);
            wr(`EPTMR_OFF_PERIOD, p);
            wr(`EPTMR_OFF_COUNT, 0);
            wr(`EPTMR_OFF_CONTROL, 4 | c);
            waitp(t);
            waitp(t);
            chk("period", t, 4 * (1 << (2 * c)) * (p + 1));
        end
        // postscale codes: matches counted until irq
        for (int k = 0; k < 3; k++) begin
            n = k == 0 ? 0 : k == 1 ? 15 : $urandom_range(14, 1);
            wr(`EPTMR_OFF_CONTROL, 0);
            wr(`EPTMR_OFF_PERIOD, 1);
            wr(`EPTMR_OFF_IRQ_EN, 1);
            wr(`EPTMR_OFF_IRQ_FLAG, 1);
            wr(`EPTMR_OFF_COUNT, 0);
            wr(`EPTMR_OFF_CONTROL, (n << 3) | 4);
            t = pwmCount;
            q = 0;
            while (irq !== 1'b1 && q < 20000) begin
                @(negedge clk);
                q++;
            end
            repeat (2) @(negedge clk);
            chk("postscale", pwmCount - t, n + 1);
        end
        // mask, sticky flag, clear by writing one
        wr(`EPTMR_OFF_IRQ_EN, 0);
        @(negedge clk);
        chk("irq masked", irq, 0);
        apb(`EPTMR_OFF_IRQ_FLAG, 1'b0, 32'h0);
        chk("flag", rd, 1);
        wr(`EPTMR_OFF_IRQ_EN, 1);
        @(negedge clk);
        chk("irq", irq, 1);
        wr(`EPTMR_OFF_CONTROL, 0);
        wr(`EPTMR_OFF_IRQ_FLAG, 1);
        @(negedge clk);
        chk("irq cleared", irq, 0);
        // off holds the count; a control write leaves it
        wr(`EPTMR_OFF_COUNT, $urandom_range(255, 0));
        repeat (50) @(posedge clk);
        wr(`EPTMR_OFF_CONTROL, 32'h01);
        rdchk(`EPTMR_OFF_COUNT);
        // sleep: turned on but frozen
        sleepMode <= 1'b1;
        repeat (4) @(posedge clk);
        wr(`EPTMR_OFF_CONTROL, 4);
        repeat (100) @(posedge clk);
        rdchk(`EPTMR_OFF_COUNT);
        sleepMode <= 1'b0;
        // shift clock stays quiet until selected, then one pulse per two ticks
        chk("shift idle", shiftCount, 0);
        wr(`EPTMR_OFF_SHIFT_SEL, 1);
        waitp(t);
        t = shiftCount;
        repeat (80) @(negedge clk);
        chk("shift pulses", shiftCount - t, 80 / (4 * 2));
        endOfTest;
    end
    // watchdog well past the expected run length
    initial begin
        #3000000;
        failCount++;
        endOfTest;
    end
endmodule
